/* File: design/ltd_consts.svh */
// Constants for the link and timer diagnostics block
`ifndef LTD_CONSTS_SVH
`define LTD_CONSTS_SVH

// Command codes
`define LTD_CMD_REFLECT     4'h5
`define LTD_CMD_DUMP        4'h6
`define LTD_CMD_DIAG        4'h7

// Result word field positions
`define LTD_LINK_HEALTHY_BIT    15
`define LTD_XCVR_PROBLEM_BIT    14
`define LTD_OPEN_CABLE_BIT      13
`define LTD_SHORTED_CABLE_BIT   12

// Delay count values
`define LTD_TIME_ALL_ONES   11'h7FF
`define LTD_TIME_ZERO       11'h000

// Register dump size and layout
`define LTD_DUMP_BYTES      8'hAA
`define LTD_DUMP_WORDS      4'h8

// Counter test values
`define LTD_CNT_ALL_ONES    10'h3FF
`define LTD_CNT_ZERO        10'h000
`define LTD_SLOT_BEFORE     10'h1FF
`define LTD_SLOT_AFTER      10'h200
`define LTD_COLL_ZERO       4'h0

// Trigger test configuration
`define LTD_DIAG_SLOT_TIME  10'h008
`define LTD_DIAG_LINEAR_PRIORITY   3'h2
`define LTD_DIAG_EXPONENTIAL_PRIORITY   3'h1
`define LTD_DIAG_BACKOFF_METHOD    1'h0

// Reset values
`define LTD_RESULT_RESET    16'h0000
`define LTD_ADDR_RESET      24'h000000

`endif

/* File: design/ltd_pkg.sv */
// Types of the link and timer diagnostics block
package ltd_pkg;

    // Sequencer states
    typedef enum logic [2:0] {
        LTD_IDLE      = 3'b000,
        LTD_REFLECT   = 3'b001,
        LTD_DUMP      = 3'b010,
        LTD_COUNT     = 3'b011,
        LTD_COUNT_CHK = 3'b100,
        LTD_TRIGGER   = 3'b101,
        LTD_TRIG_CHK  = 3'b110,
        LTD_FINISH    = 3'b111
    } ltd_state_t;

    // Pin synchroniser state
    typedef struct packed {
        logic txc_meta;
        logic txc_sync;
        logic txc_prev;
        logic cdt_meta;
        logic cdt_sync;
        logic crs_meta;
        logic crs_sync;
    } ltd_sync_state_t;

    // Sequencer state
    typedef struct packed {
        ltd_state_t  state;
        logic [15:0] result;
        logic [10:0] delay;
        logic        carrier_seen;
        logic        busy;
        logic        done;
        logic        ok;
        logic [15:0] pointer;
        logic [23:0] base;
        logic [7:0]  idx;
        logic        mem_wr;
        logic [23:0] mem_addr;
        logic [7:0]  mem_data;
        logic [9:0]  free_run;
        logic [9:0]  backoff;
        logic [9:0]  slot;
        logic        slot_pre;
        logic [3:0]  coll;
        logic [9:0]  shift;
        logic [2:0]  linear_priority;
        logic [2:0]  exponential_priority;
        logic        backoff_method;
        logic [9:0]  slot_time;
        logic        serial_active;
        logic        serial_data;
    } ltd_core_state_t;

endpackage : ltd_pkg

/* File: design/ltd_link_if.sv */
// Synchronised link events passed from the pin sampler to the sequencer
`timescale 1ns/1ps
interface ltd_link_if;
    logic txc_fall;
    logic collision;
    logic carrier;

    modport sampler (output txc_fall, output collision, output carrier);
    modport core    (input  txc_fall, input  collision, input  carrier);
endinterface : ltd_link_if

/* File: design/ltd_link_sync.sv */
// Two-stage synchronisers and clock edge finder for the serial link pins
`timescale 1ns/1ps
module ltd_link_sync (
    // Clock and reset
    input  wire logic   mclk_i,
    input  wire logic   reset_n_i,
    // Raw link pins
    input  wire logic   transmit_serial_clock_i,
    input  wire logic   collision_detect_in_n_i,
    input  wire logic   carrier_sense_in_n_i,
    // Synchronised events
    ltd_link_if.sampler link
);

    ltd_pkg::ltd_sync_state_t s_r;
    ltd_pkg::ltd_sync_state_t s_nxt;

    // Meta stages feed only the second stage
    always_comb
    begin
        s_nxt          = s_r;
        s_nxt.txc_meta = transmit_serial_clock_i;
        s_nxt.txc_sync = s_r.txc_meta;
        s_nxt.txc_prev = s_r.txc_sync;
        s_nxt.cdt_meta = collision_detect_in_n_i;
        s_nxt.cdt_sync = s_r.cdt_meta;
        s_nxt.crs_meta = carrier_sense_in_n_i;
        s_nxt.crs_sync = s_r.crs_meta;
    end

    // Pins idle high, so reset to the inactive level
    always_ff @(posedge mclk_i)
    begin
        if (!reset_n_i)
            s_r <= '1;
        else
            s_r <= s_nxt;
    end

    // Falling edge of the transmit clock, active-low pins turned to active high
    assign link.txc_fall  = s_r.txc_prev & ~s_r.txc_sync;
    assign link.collision = ~s_r.cdt_sync;
    assign link.carrier   = ~s_r.crs_sync;

endmodule : ltd_link_sync

/* File: design/ltd_diag.sv */
// Diagnostic command executor: reflectometer, register dump and timer self-test
//
// Function
// - Reflectometer start sends all ones and starts the delay timer together.
// - Timer stops on collision detect active or carrier sense dropping.
// - Command code 5 selects the reflectometer test.
// - Echo delay is an 11-bit count of transmit clock cycles.
// - No echo gives a delay count of all ones.
// - Healthy link sets bit 15 and delay 7FF.
// - Transceiver fault sets bit 14, clears bit 15, delay 7FF.
// - Open cable sets bit 13 and clears bit 15.
// - Shorted cable sets bit 12 and clears bit 15.
// - Command code 6 selects the register dump.
// - Register dump writes internal register contents to host memory.
// - Dump destination offset comes from the 16-bit dump pointer.
// - Command code 7 selects the timer self-test.
// - Phase one clears all four counters together, then counts.
// - Free-running and backoff counters wrap from all ones together.
// - Slot counter steps 1FF to 200, collision counter wraps, same moment.
// - Counting stops when any of the three long counters transitions.
// - Free-running, backoff and collision counters checked for zero, slot counter for 200; else fail.
// - Phase two clears shift register, backoff, slot and collision counters, sets free-running to all ones, loads fixed backoff setup.
// - Emulate transmission with collision until shift register top bit is one.
// - Mask logic output all ones passes, otherwise fails.
`timescale 1ns/1ps
`include "ltd_consts.svh"
module ltd_diag (
    // Clock and reset
    input  wire logic        mclk_i,
    input  wire logic        reset_n_i,
    // Command request
    input  wire logic        cmd_start_i,
    input  wire logic [3:0]  cmd_code_i,
    input  wire logic [15:0] dump_pointer_i,
    input  wire logic [23:0] mem_base_i,
    // Command answer
    output logic             cmd_busy_o,
    output logic             cmd_done_o,
    output logic             cmd_ok_o,
    output logic [15:0]      result_word_o,
    // Host memory write port
    output logic             mem_wr_o,
    output logic [23:0]      mem_addr_o,
    output logic [7:0]       mem_data_o,
    input  wire logic        mem_ack_i,
    // Serial link
    input  wire logic        transmit_serial_clock_i,
    input  wire logic        collision_detect_in_n_i,
    input  wire logic        carrier_sense_in_n_i,
    output logic             serial_data_o,
    output logic             serial_active_o
);

    ltd_pkg::ltd_core_state_t s_r;
    ltd_pkg::ltd_core_state_t s_nxt;

    ltd_link_if link ();

    // Pin synchronisers
    ltd_link_sync u_sync (
        .mclk_i                  (mclk_i),
        .reset_n_i               (reset_n_i),
        .transmit_serial_clock_i (transmit_serial_clock_i),
        .collision_detect_in_n_i (collision_detect_in_n_i),
        .carrier_sense_in_n_i    (carrier_sense_in_n_i),
        .link                    (link)
    );

    // Picks the internal register shown by one dump word
    function automatic logic [15:0] dump_word(input ltd_pkg::ltd_core_state_t st, input logic [6:0] w);
        logic [15:0] v;
        v = 16'h0000;
        case (w)
            7'h00:   v = st.result;
            7'h01:   v = {6'h00, st.free_run};
            7'h02:   v = {6'h00, st.backoff};
            7'h03:   v = {6'h00, st.slot};
            7'h04:   v = {11'h000, st.slot_pre, st.coll};
            7'h05:   v = {6'h00, st.shift};
            7'h06:   v = {8'h00, st.backoff_method, st.exponential_priority, 1'b0, st.linear_priority};
            7'h07:   v = st.pointer;
            default: v = 16'h0000;
        endcase
        return v;
    endfunction : dump_word

    // Byte of the dump image at a given index, low byte first
    function automatic logic [7:0] dump_byte(input ltd_pkg::ltd_core_state_t st, input logic [7:0] i);
        logic [15:0] w;
        w = dump_word(st, i[7:1]);
        return i[0] ? w[15:8] : w[7:0];
    endfunction : dump_byte

    // Next-state logic of the sequencer
    always_comb
    begin
        logic [9:0]  nfree;
        logic [9:0]  nbo;
        logic [9:0]  nslot;
        logic        stop;
        logic [9:0]  mask;
        logic [15:0] res;
        nfree = s_r.free_run + 10'h001;
        nbo   = s_r.backoff + 10'h001;
        nslot = s_r.slot + {9'h000, s_r.slot_pre};
        stop  = 1'b0;
        mask  = s_r.free_run & s_r.shift;
        res   = `LTD_RESULT_RESET;
        s_nxt      = s_r;
        s_nxt.done = 1'b0;
        case (s_r.state)
            ltd_pkg::LTD_IDLE:
            begin
                if (cmd_start_i)
                begin
                    s_nxt.busy    = 1'b1;
                    s_nxt.pointer = dump_pointer_i;
                    s_nxt.base    = mem_base_i;
                    case (cmd_code_i)
                        `LTD_CMD_REFLECT:
                        begin
                            s_nxt.state         = ltd_pkg::LTD_REFLECT;
                            s_nxt.delay         = `LTD_TIME_ZERO;
                            s_nxt.carrier_seen  = 1'b0;
                            s_nxt.serial_active = 1'b1;
                            s_nxt.serial_data   = 1'b1;
                        end
                        `LTD_CMD_DUMP:
                        begin
                            s_nxt.state    = ltd_pkg::LTD_DUMP;
                            s_nxt.idx      = 8'h00;
                            s_nxt.mem_wr   = 1'b1;
                            s_nxt.mem_addr = mem_base_i + {8'h00, dump_pointer_i};
                            s_nxt.mem_data = dump_byte(s_r, 8'h00);
                        end
                        `LTD_CMD_DIAG:
                        begin
                            s_nxt.state    = ltd_pkg::LTD_COUNT;
                            s_nxt.free_run = `LTD_CNT_ZERO;
                            s_nxt.backoff  = `LTD_CNT_ZERO;
                            s_nxt.slot     = `LTD_CNT_ZERO;
                            s_nxt.slot_pre = 1'b0;
                            s_nxt.coll     = `LTD_COLL_ZERO;
                        end
                        default:
                        begin
                            // Unknown codes finish at once with a failed status
                            s_nxt.state = ltd_pkg::LTD_FINISH;
                            s_nxt.ok    = 1'b0;
                        end
                    endcase
                end
            end
            ltd_pkg::LTD_REFLECT:
            begin
                if (link.carrier)
                    s_nxt.carrier_seen = 1'b1;
                // Echo by collision means the wave came back from an open end
                if (link.collision)
                begin
                    res[`LTD_OPEN_CABLE_BIT] = 1'b1;
                    res[10:0]                = s_r.delay;
                    s_nxt.state              = ltd_pkg::LTD_FINISH;
                end
                // Carrier that drops after being seen is read as a short
                else if (s_r.carrier_seen && !link.carrier)
                begin
                    res[`LTD_SHORTED_CABLE_BIT] = 1'b1;
                    res[10:0]                   = s_r.delay;
                    s_nxt.state                 = ltd_pkg::LTD_FINISH;
                end
                else if (link.txc_fall && s_r.delay == `LTD_TIME_ALL_ONES)
                begin
                    // Timer ran out without echo
                    res[10:0] = `LTD_TIME_ALL_ONES;
                    if (s_r.carrier_seen)
                        res[`LTD_LINK_HEALTHY_BIT] = 1'b1;
                    else
                        res[`LTD_XCVR_PROBLEM_BIT] = 1'b1;
                    s_nxt.state = ltd_pkg::LTD_FINISH;
                end
                else if (link.txc_fall)
                    s_nxt.delay = s_r.delay + 11'h001;
                if (s_nxt.state == ltd_pkg::LTD_FINISH)
                begin
                    s_nxt.result        = res;
                    s_nxt.ok            = res[`LTD_LINK_HEALTHY_BIT];
                    s_nxt.serial_active = 1'b0;
                end
            end
            ltd_pkg::LTD_DUMP:
            begin
                // Each byte stands until the memory side takes it
                if (mem_ack_i)
                begin
                    if (s_r.idx == `LTD_DUMP_BYTES - 8'h01)
                    begin
                        s_nxt.mem_wr = 1'b0;
                        s_nxt.ok     = 1'b1;
                        s_nxt.state  = ltd_pkg::LTD_FINISH;
                    end
                    else
                    begin
                        s_nxt.idx      = s_r.idx + 8'h01;
                        s_nxt.mem_addr = s_r.mem_addr + 24'h000001;
                        s_nxt.mem_data = dump_byte(s_r, s_r.idx + 8'h01);
                    end
                end
            end
            ltd_pkg::LTD_COUNT:
            begin
                // All four counters step together; slot counts at half rate
                s_nxt.free_run = nfree;
                s_nxt.backoff  = nbo;
                s_nxt.slot     = nslot;
                s_nxt.slot_pre = ~s_r.slot_pre;
                s_nxt.coll     = s_r.coll + 4'h1;
                stop = (s_r.free_run == `LTD_CNT_ALL_ONES) ||
                       (s_r.backoff == `LTD_CNT_ALL_ONES) ||
                       (s_r.slot == `LTD_SLOT_BEFORE && s_r.slot_pre);
                if (stop)
                    s_nxt.state = ltd_pkg::LTD_COUNT_CHK;
            end
            ltd_pkg::LTD_COUNT_CHK:
            begin
                // Checking at the transition catches a counter that wrapped early or late
                if (s_r.free_run == `LTD_CNT_ZERO && s_r.backoff == `LTD_CNT_ZERO &&
                    s_r.slot == `LTD_SLOT_AFTER && s_r.coll == `LTD_COLL_ZERO)
                begin
                    s_nxt.state     = ltd_pkg::LTD_TRIGGER;
                    s_nxt.shift     = `LTD_CNT_ZERO;
                    s_nxt.backoff   = `LTD_CNT_ZERO;
                    s_nxt.slot      = `LTD_CNT_ZERO;
                    s_nxt.slot_pre  = 1'b0;
                    s_nxt.coll      = `LTD_COLL_ZERO;
                    s_nxt.free_run  = `LTD_CNT_ALL_ONES;
                    s_nxt.slot_time = `LTD_DIAG_SLOT_TIME;
                    s_nxt.linear_priority  = `LTD_DIAG_LINEAR_PRIORITY;
                    s_nxt.exponential_priority  = `LTD_DIAG_EXPONENTIAL_PRIORITY;
                    s_nxt.backoff_method   = `LTD_DIAG_BACKOFF_METHOD;
                end
                else
                begin
                    s_nxt.ok    = 1'b0;
                    s_nxt.state = ltd_pkg::LTD_FINISH;
                end
            end
            ltd_pkg::LTD_TRIGGER:
            begin
                // One emulated frame lasts one slot time, then collides
                if (s_r.shift[9])
                    s_nxt.state = ltd_pkg::LTD_TRIG_CHK;
                else if (s_r.slot == s_r.slot_time - 10'h001)
                begin
                    s_nxt.slot  = `LTD_CNT_ZERO;
                    s_nxt.shift = {s_r.shift[8:0], 1'b1};
                    s_nxt.coll  = s_r.coll + 4'h1;
                end
                else
                    s_nxt.slot = s_r.slot + 10'h001;
            end
            ltd_pkg::LTD_TRIG_CHK:
            begin
                s_nxt.ok    = (mask == `LTD_CNT_ALL_ONES);
                s_nxt.state = ltd_pkg::LTD_FINISH;
            end
            ltd_pkg::LTD_FINISH:
            begin
                s_nxt.busy  = 1'b0;
                s_nxt.done  = 1'b1;
                s_nxt.state = ltd_pkg::LTD_IDLE;
            end
            default:
                s_nxt.state = ltd_pkg::LTD_IDLE;
        endcase
    end

    // State register; the line idles marking
    always_ff @(posedge mclk_i)
    begin
        if (!reset_n_i)
        begin
            s_r             <= '0;
            s_r.state       <= ltd_pkg::LTD_IDLE;
            s_r.serial_data <= 1'b1;
        end
        else
            s_r <= s_nxt;
    end

    // Outputs straight from the state register
    assign cmd_busy_o      = s_r.busy;
    assign cmd_done_o      = s_r.done;
    assign cmd_ok_o        = s_r.ok;
    assign result_word_o   = s_r.result;
    assign mem_wr_o        = s_r.mem_wr;
    assign mem_addr_o      = s_r.mem_addr;
    assign mem_data_o      = s_r.mem_data;
    assign serial_data_o   = s_r.serial_data;
    assign serial_active_o = s_r.serial_active;

endmodule : ltd_diag

/* File: tb/ltd_diag_chk.sv */
// Concurrent checks on the diagnostic command executor ports
`timescale 1ns/1ps
`include "ltd_consts.svh"
module ltd_diag_chk (
    // Clock and reset
    input  wire logic        mclk_i,
    input  wire logic        reset_n_i,
    // Command side
    input  wire logic        cmd_start_i,
    input  wire logic [3:0]  cmd_code_i,
    input  wire logic [15:0] dump_pointer_i,
    input  wire logic [23:0] mem_base_i,
    input  wire logic        cmd_busy_o,
    input  wire logic        cmd_done_o,
    input  wire logic        cmd_ok_o,
    input  wire logic [15:0] result_word_o,
    // Memory and link side
    input  wire logic        mem_wr_o,
    input  wire logic [23:0] mem_addr_o,
    input  wire logic [7:0]  mem_data_o,
    input  wire logic        mem_ack_i,
    input  wire logic        collision_detect_in_n_i,
    input  wire logic        serial_data_o,
    input  wire logic        serial_active_o
);
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!reset_n_i);

    // Accepted starts; the done cycle counts as idle
    sequence s_go_reflect;
        cmd_start_i && !cmd_busy_o && cmd_code_i == `LTD_CMD_REFLECT;
    endsequence
    sequence s_go_dump;
        cmd_start_i && !cmd_busy_o && cmd_code_i == `LTD_CMD_DUMP;
    endsequence
    sequence s_go_other;
        cmd_start_i && !cmd_busy_o && !(cmd_code_i inside {`LTD_CMD_REFLECT, `LTD_CMD_DUMP, `LTD_CMD_DIAG});
    endsequence
    sequence s_byte_taken;
        mem_wr_o && mem_ack_i;
    endsequence
    // Collision must be held past the two-flop synchroniser
    sequence s_coll_held;
        serial_active_o && !collision_detect_in_n_i ##1 !collision_detect_in_n_i [*2];
    endsequence

    a_reflect_start_tx: assert property (s_go_reflect |=> serial_active_o && cmd_busy_o)
        else $error("reflectometer start did not begin transmission");
    a_tx_all_ones: assert property (serial_active_o |-> serial_data_o)
        else $error("pattern bit not one while transmitting");
    a_echo_stops_tx: assert property (s_coll_held |-> ##[1:6] !serial_active_o)
        else $error("collision echo did not stop the test");
    a_dump_first_addr: assert property (s_go_dump |=>
        mem_wr_o && mem_addr_o == $past(mem_base_i) + {8'h00, $past(dump_pointer_i)})
        else $error("first dump byte at wrong address");
    a_dump_ascend: assert property (s_byte_taken ##1 mem_wr_o |-> mem_addr_o == $past(mem_addr_o) + 24'h000001)
        else $error("dump address not ascending by one");
    a_dump_hold: assert property (mem_wr_o && !mem_ack_i |=>
        mem_wr_o && $stable(mem_addr_o) && $stable(mem_data_o))
        else $error("dump write changed before acknowledge");
    a_other_code_fails: assert property (s_go_other |=> cmd_busy_o ##1 (cmd_done_o && !cmd_ok_o))
        else $error("unknown code not finished as failed");
    a_healthy_delay: assert property (result_word_o[15] |->
        result_word_o[14:11] == 4'h0 && result_word_o[10:0] == `LTD_TIME_ALL_ONES)
        else $error("healthy result with wrong flags or delay");
    a_xcvr_delay: assert property (result_word_o[14] |-> result_word_o[10:0] == `LTD_TIME_ALL_ONES)
        else $error("transceiver fault without full delay");
    a_fault_clears_ok: assert property (|result_word_o[14:12] |->
        !result_word_o[15] && $onehot(result_word_o[14:12]))
        else $error("fault flag set with healthy flag");
endmodule : ltd_diag_chk

bind ltd_diag ltd_diag_chk i_ltd_diag_chk (
    .mclk_i(mclk_i), .reset_n_i(reset_n_i), .cmd_start_i(cmd_start_i), .cmd_code_i(cmd_code_i),
    .dump_pointer_i(dump_pointer_i), .mem_base_i(mem_base_i), .cmd_busy_o(cmd_busy_o),
    .cmd_done_o(cmd_done_o), .cmd_ok_o(cmd_ok_o), .result_word_o(result_word_o), .mem_wr_o(mem_wr_o),
    .mem_addr_o(mem_addr_o), .mem_data_o(mem_data_o), .mem_ack_i(mem_ack_i),
    .collision_detect_in_n_i(collision_detect_in_n_i), .serial_data_o(serial_data_o),
    .serial_active_o(serial_active_o)
);

/* File: tb/ltd_link_model.sv */
// Behavioural transceiver and cable answering the reflectometer pattern
`timescale 1ns/1ps
module ltd_link_model (
    // Echo setup: 0 open, 1 short, 2 healthy, 3 dead transceiver
    input  wire logic        serial_active_i,
    input  wire logic [1:0]  echo_mode_i,
    input  wire logic [10:0] echo_at_i,
    // Link pins, idle high through pull-ups
    output logic             transmit_serial_clock_o,
    output logic             collision_detect_in_n_o,
    output logic             carrier_sense_in_n_o
);
    int falls;

    // Pins start released, clock standing still
    initial
    begin
        transmit_serial_clock_o = 1'b1;
        collision_detect_in_n_o = 1'b1;
        carrier_sense_in_n_o    = 1'b1;
    end

    // Clock runs only during the test; echoes change on the rising half so counts are exact
    always @(posedge serial_active_i)
    begin
        #1; // Keep pin changes off the system clock edges, no race with the sampler
        falls = 0;
        while (serial_active_i === 1'b1 && falls < 2200)
        begin
            #80 transmit_serial_clock_o = 1'b0;
            falls = falls + 1;
            #80 transmit_serial_clock_o = 1'b1;
            if ((echo_mode_i == 2'h1 || echo_mode_i == 2'h2) && falls == 2)
                carrier_sense_in_n_o = 1'b0; // Own carrier seen back
            if (echo_mode_i == 2'h0 && falls == int'(echo_at_i))
                collision_detect_in_n_o = 1'b0; // Open cable reflects as collision
            if (echo_mode_i == 2'h1 && falls == int'(echo_at_i))
                carrier_sense_in_n_o = 1'b1; // Short kills the carrier
        end
        collision_detect_in_n_o = 1'b1;
        carrier_sense_in_n_o    = 1'b1;
    end
endmodule : ltd_link_model

/* File: tb/tb.sv */
// Self-checking bench for the diagnostic command executor
`timescale 1ns/1ps
module tb;
    logic        mclk_i         = 1'b0;
    logic        reset_n_i      = 1'b0;
    logic        cmd_start_i    = 1'b0;
    logic [3:0]  cmd_code_i     = 4'h0;
    logic [15:0] dump_pointer_i = 16'h0000;
    logic [23:0] mem_base_i     = 24'h000000;
    logic        mem_ack_i      = 1'b0;
    logic [1:0]  echo_mode      = 2'h0;
    logic [10:0] echo_at        = 11'h000;
    logic [7:0]  lfsr           = 8'h5E;
    logic        transmit_serial_clock, cdt_n, crs_n, busy, done, ok, wr, sdata, sact;
    logic [15:0] res, ptr;
    logic [23:0] addr, base;
    logic [7:0]  data, b;
    logic [31:0] done_q[$], mem_q[$], mem_m[$];
    int          fail_count     = 0;
    int          total_checks   = 0;

    always #2.5 mclk_i = ~mclk_i;

    ltd_diag i_ltd_diag (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .cmd_start_i(cmd_start_i),
        .cmd_code_i(cmd_code_i), .dump_pointer_i(dump_pointer_i), .mem_base_i(mem_base_i),
        .cmd_busy_o(busy), .cmd_done_o(done), .cmd_ok_o(ok), .result_word_o(res), .mem_wr_o(wr),
        .mem_addr_o(addr), .mem_data_o(data), .mem_ack_i(mem_ack_i), .transmit_serial_clock_i(transmit_serial_clock),
        .collision_detect_in_n_i(cdt_n), .carrier_sense_in_n_i(crs_n), .serial_data_o(sdata),
        .serial_active_o(sact));
    ltd_link_model i_ltd_link_model (.serial_active_i(sact), .echo_mode_i(echo_mode), .echo_at_i(echo_at),
        .transmit_serial_clock_o(transmit_serial_clock), .collision_detect_in_n_o(cdt_n), .carrier_sense_in_n_o(crs_n));

    function automatic logic [7:0] lfsr_next(input logic [7:0] s);
        lfsr_next = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr_next

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic give_verdict;
        $display("Checks made %0d, mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : give_verdict

    // Issue one command, optionally poke a refused start, wait for done under a bound
    task automatic run_cmd(input logic [3:0] code, input logic exp_ok, input logic [15:0] exp_res,
                           input logic poke, input int limit);
        int n;
        done_q.push_back({15'h0000, exp_ok, exp_res});
        // Link model may still be in its last clock period with echoes held; let it release
        repeat (40) @(posedge mclk_i);
        cmd_start_i <= 1'b1;
        cmd_code_i  <= code;
        @(posedge mclk_i);
        cmd_start_i <= 1'b0;
        if (poke)
        begin
            repeat (20) @(posedge mclk_i);
            cmd_start_i <= 1'b1;
            cmd_code_i  <= 4'h6;
            @(posedge mclk_i);
            cmd_start_i <= 1'b0;
        end
        n = 0;
        while (done !== 1'b1 && n < limit)
        begin
            @(posedge mclk_i);
            n++;
        end
        if (n >= limit)
        begin
            check(32'h1, 32'h0);
            give_verdict();
        end
    endtask : run_cmd

    // Random acknowledge stalls the dump writes
    always @(posedge mclk_i)
    begin
        lfsr      <= lfsr_next(lfsr);
        mem_ack_i <= lfsr[0] | lfsr[2];
    end

    // Monitor: every result takes the oldest note; an unexpected one hits an empty queue
    always @(posedge mclk_i)
    begin
        if (reset_n_i === 1'b1 && done === 1'b1)
        begin
            if (done_q.size() == 0)
                check(32'h1, 32'h0);
            else
                check({15'h0000, ok, res}, done_q.pop_front());
        end
        if (reset_n_i === 1'b1 && wr === 1'b1 && mem_ack_i === 1'b1)
        begin
            if (mem_q.size() == 0)
                check(32'h2, 32'h0);
            else
                check({data, addr} & mem_m.pop_front(), mem_q.pop_front());
        end
    end

    // Main sequence
    initial
    begin
        repeat (5) @(posedge mclk_i);
        reset_n_i <= 1'b1;
        @(posedge mclk_i);
        check({10'h000, sdata, sact, busy, done, ok, wr, res}, 32'h00200000);
        for (int c = 0; c < 16; c++)
            if (c < 5 || c > 7)
                run_cmd(4'(c), 1'b0, 16'h0000, 1'b0, 20);
        echo_mode <= 2'h0;
        echo_at   <= 11'h025;
        run_cmd(4'h5, 1'b0, 16'h2025, 1'b0, 5000);
        echo_mode <= 2'h1;
        echo_at   <= 11'h064;
        run_cmd(4'h5, 1'b0, 16'h1064, 1'b0, 6000);
        echo_mode <= 2'h2;
        echo_at   <= 11'h000;
        run_cmd(4'h5, 1'b1, 16'h87FF, 1'b0, 70000);
        ptr = {lfsr, lfsr_next(lfsr)};
        base = {8'h3C, lfsr, 8'hF8};
        dump_pointer_i <= ptr;
        mem_base_i     <= base;
        // Host buffer of 170 bytes at the pointer; internal counter words are not predicted
        for (int i = 0; i < 170; i++)
        begin
            b = (i == 0) ? 8'hFF : (i == 1) ? 8'h87 : (i == 14) ? ptr[7:0] : (i == 15) ? ptr[15:8] : 8'h00;
            mem_q.push_back({b, base + {8'h00, ptr} + 24'(i)});
            mem_m.push_back({(i > 1 && i < 14) ? 8'h00 : 8'hFF, 24'hFFFFFF});
        end
        run_cmd(4'h6, 1'b1, 16'h87FF, 1'b0, 3000);
        check(32'(mem_q.size()), 32'h0);
        run_cmd(4'h7, 1'b1, 16'h87FF, 1'b1, 4000);
        repeat (4) @(posedge mclk_i);
        give_verdict();
    end
endmodule : tb
